// File: sink_fade_regs.vh
// Register addresses, field positions, reset values and timing constants for the sink fade block.
// Assumes the host interface delivers decoded byte writes and reads on the device clock.
`ifndef SINK_FADE_REGS_VH
`define SINK_FADE_REGS_VH

// ****************************************
// Register map
// ****************************************
`define ADDR_SINK_FADE 8'h13
`define ADDR_SINK_ENABLE 8'h10
`define FADE_RESET 8'h00
`define ENABLE_RESET 8'h00
`define FADE_DOWN_MSB 7
`define FADE_DOWN_LSB 4
`define FADE_UP_MSB 3
`define FADE_UP_LSB 0
`define READ_ZERO 8'h00

// ****************************************
// Sinks and timing
// ****************************************
`define SINK_COUNT 7
`define LEVEL_BITS 7
`define LEVEL_ZERO 7'h00
`define LEVEL_ONE 7'h01
`define FULL_SCALE_STEPS 127
`define CLOCK_KHZ 40000
`define FADE_UNIT_MS 100
`define FADE_OFF 4'h0
`define SHORT_CODE_LAST 4'hA
`define SHORT_UNITS_PER_CODE 6'h03
`define LONG_FIRST_UNITS 6'h23
`define LONG_UNITS_PER_CODE 6'h05
`define LONG_CODE_FIRST 4'hB
`define UNIT_COUNT_ZERO 6'h00
`define UNIT_COUNT_ONE 6'h01
`define TICK_BITS 15
`define TICK_ZERO 15'h0000
`define TICK_ONE 15'h0001

`endif

// File: sink_current_fade.v
// Fade engine for the seven independent sinks: fade rate register, enable register, current ramps.
// Assumes the serial host interface presents one-cycle read and write strobes on the device clock.
`timescale 1ns/100ps
`include "sink_fade_regs.vh"

module sink_current_fade #(
  parameter TICK_CYCLES = (`FADE_UNIT_MS * `CLOCK_KHZ) / `FULL_SCALE_STEPS
) (
  // Clock, reset, clock enable
  input wire clock,
  input wire rst,
  input wire ce,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // Per-sink target levels from the current-level registers, sink 0 in the low bits
  input wire [`SINK_COUNT*`LEVEL_BITS-1:0] sink_target,
  // Per-sink present levels to the current DACs
  output wire [`SINK_COUNT*`LEVEL_BITS-1:0] sink_level,
  output wire [`SINK_COUNT-1:0] sink_enable_bits
);

  // ****************************************
  // Derived constants
  // ****************************************
  // The prescaler wraps on its last count; the result is cut to the counter width on purpose.
  localparam integer TICK_LAST_INT = TICK_CYCLES - 1;
  localparam [`TICK_BITS-1:0] TICK_LAST = TICK_LAST_INT[`TICK_BITS-1:0];

  // ****************************************
  // Register decode
  // ****************************************
  reg [7:0] sink_fade_register;
  reg [`SINK_COUNT-1:0] enable_reg;
  reg [7:0] next_rdata;
  wire write_fade = reg_write && (reg_addr == `ADDR_SINK_FADE);
  wire write_enable = reg_write && (reg_addr == `ADDR_SINK_ENABLE);
  wire read_fade = reg_read && (reg_addr == `ADDR_SINK_FADE);
  wire read_enable = reg_read && (reg_addr == `ADDR_SINK_ENABLE);
  wire [3:0] sink_ramp_down_rate = sink_fade_register[`FADE_DOWN_MSB:`FADE_DOWN_LSB];
  wire [3:0] sink_ramp_up_rate = sink_fade_register[`FADE_UP_MSB:`FADE_UP_LSB];

  assign sink_enable_bits = enable_reg;

  // ****************************************
  // Read data selection
  // ****************************************
  // Read data is only reloaded by a read strobe, so it stands until the next read.
  always @* begin
    next_rdata = reg_rdata;
    if (read_fade) begin
      next_rdata = sink_fade_register;
    end else if (read_enable) begin
      next_rdata = {1'b0, enable_reg};
    end else if (reg_read) begin
      next_rdata = `READ_ZERO;
    end
  end

  // ****************************************
  // Register storage
  // ****************************************
  always @(posedge clock) begin
    if (rst) begin
      sink_fade_register <= `FADE_RESET;
      enable_reg <= {`SINK_COUNT{1'b0}};
      reg_rdata <= `READ_ZERO;
    end else if (ce) begin
      if (write_fade) begin
        sink_fade_register <= reg_wdata;
      end
      if (write_enable) begin
        enable_reg <= reg_wdata[`SINK_COUNT-1:0];
      end
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Fade duration decode
  // ****************************************
  // Returns the number of 0.1 s units in a full-scale fade; each unit spans one tick per level step.
  function [5:0] fade_units;
    input [3:0] code;
    begin
      if (code <= `SHORT_CODE_LAST) begin
        fade_units = `SHORT_UNITS_PER_CODE * {2'b00, code};
      end else begin
        fade_units = `LONG_FIRST_UNITS + `LONG_UNITS_PER_CODE * {2'b00, code - `LONG_CODE_FIRST};
      end
    end
  endfunction

  wire [5:0] down_units = fade_units(sink_ramp_down_rate);
  wire [5:0] up_units = fade_units(sink_ramp_up_rate);
  wire down_off = (sink_ramp_down_rate == `FADE_OFF);
  wire up_off = (sink_ramp_up_rate == `FADE_OFF);

  // ****************************************
  // Shared timebase
  // ****************************************
  // One tick is 0.1 s divided over the full-scale step count.
  reg [`TICK_BITS-1:0] tick_count;
  reg [`TICK_BITS-1:0] next_tick_count;
  wire tick = (tick_count == TICK_LAST);

  always @* begin
    next_tick_count = tick_count + `TICK_ONE;
    if (write_enable) begin
      next_tick_count = `TICK_ZERO;
    end else if (tick) begin
      next_tick_count = `TICK_ZERO;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      tick_count <= `TICK_ZERO;
    end else if (ce) begin
      tick_count <= next_tick_count;
    end
  end

  // ****************************************
  // Per-sink ramps
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < `SINK_COUNT; i = i + 1) begin : g_sink
      reg [`LEVEL_BITS-1:0] level;
      reg [5:0] unit_count;
      reg [`LEVEL_BITS-1:0] next_level;
      reg [5:0] next_unit_count;
      wire [`LEVEL_BITS-1:0] target = sink_target[i*`LEVEL_BITS +: `LEVEL_BITS];
      wire [`LEVEL_BITS-1:0] goal = enable_reg[i] ? target : `LEVEL_ZERO;
      wire at_goal = (goal == level);
      wire rising = goal > level;
      wire fade_off = rising ? up_off : down_off;
      wire [5:0] units = rising ? up_units : down_units;
      wire unit_done = (unit_count + `UNIT_COUNT_ONE >= units);

      assign sink_level[i*`LEVEL_BITS +: `LEVEL_BITS] = level;

      // Fixed time per level step makes partial fades proportionally shorter.
      always @* begin
        next_level = level;
        next_unit_count = unit_count;
        if (write_enable) begin
          next_unit_count = `UNIT_COUNT_ZERO;
        end else if (at_goal) begin
          next_unit_count = `UNIT_COUNT_ZERO;
        end else if (fade_off) begin
          next_level = goal;
          next_unit_count = `UNIT_COUNT_ZERO;
        end else if (tick) begin
          if (unit_done) begin
            next_unit_count = `UNIT_COUNT_ZERO;
            if (rising) begin
              next_level = level + `LEVEL_ONE;
            end else begin
              next_level = level - `LEVEL_ONE;
            end
          end else begin
            next_unit_count = unit_count + `UNIT_COUNT_ONE;
          end
        end
      end

      always @(posedge clock) begin
        if (rst) begin
          level <= `LEVEL_ZERO;
          unit_count <= `UNIT_COUNT_ZERO;
        end else if (ce) begin
          level <= next_level;
          unit_count <= next_unit_count;
        end
      end
    end
  endgenerate

endmodule // sink_current_fade

// File: fade_props.sv
// Port checker for the sink fade block.
// Assumes it is bound to sink_current_fade and that ce is held high.
`timescale 1ns/100ps
module fade_props (
  input logic clock, rst, reg_write, reg_read,
  input logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input logic [48:0] sink_target, sink_level,
  input logic [6:0] sink_enable_bits
);
  wire [6:0] l0 = sink_level[6:0];
  wire [6:0] g0 = sink_enable_bits[0] ? sink_target[6:0] : 7'h00;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_fade_readback: assert property (reg_write && reg_addr == 8'h13 ##1 !reg_write ##1 reg_read && !reg_write
    && reg_addr == 8'h13 |=> reg_rdata == $past(reg_wdata, 3)) else $error("fade readback wrong");
  a_unmapped_zero: assert property (reg_read && reg_addr != 8'h13 && reg_addr != 8'h10
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_enable_write: assert property (reg_write && reg_addr == 8'h10
    |=> {1'b0, sink_enable_bits} == ($past(reg_wdata) & 8'h7F)) else $error("enable write wrong");
  a_rise_toward: assert property (l0 > $past(l0) |-> $past(l0) < $past(g0)) else $error("rise away");
  a_fall_toward: assert property (l0 < $past(l0) |-> $past(l0) > $past(g0)) else $error("fall away");
  a_hold_goal: assert property (l0 == g0 ##1 $stable(g0) |-> $stable(l0)) else $error("level left goal");
  a_sinks_aligned: assert property (reg_write && reg_addr == 8'h10 && reg_wdata[1:0] == 2'b11
    && l0 == sink_level[13:7] && sink_target[6:0] == sink_target[13:7]
    |=> (l0 == sink_level[13:7]) [*8]) else $error("sinks not aligned");
  a_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata)) else $error("read data moved");
endmodule // fade_props

// File: fade_host.sv
// Host model driving the register port on falling edges.
// Assumes one-cycle strobes and read data one cycle after the read edge.
`timescale 1ns/100ps
module fade_host (
  input logic clock,
  input logic [7:0] reg_rdata,
  output logic [7:0] reg_addr, reg_wdata,
  output logic reg_write, reg_read
);
  initial {reg_addr, reg_wdata, reg_write, reg_read} = 18'h0;
  task automatic wr(input logic [7:0] a, dat);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = dat;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    reg_wdata = ~dat;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    @(negedge clock);
    dat = reg_rdata;
  endtask
endmodule // fade_host

// File: tb_top.sv
// Self-checking bench for the sink fade block.
// Assumes the host model and the checker are compiled beforehand.
`timescale 1ns/100ps
module tb_top;
  localparam int T = 2;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_write, reg_read;
  logic [48:0] sink_target = {7{7'h03}};
  logic [48:0] sink_level;
  logic [6:0] sink_enable_bits;
  int n_mismatch = 0, n_checks = 0, cyc = 0, n;
  always #12.5 clock = ~clock;
  sink_current_fade #(.TICK_CYCLES(T)) i_dut (.clock, .rst, .ce(1'b1), .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .sink_target, .sink_level, .sink_enable_bits);
  fade_host i_host (.clock, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read);
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, exp);
    i_host.rd(a, d);
    chk(d, exp);
  endtask
  // Cycles from one level step of sink 0 to the next.
  task automatic gap(output int c);
    logic [6:0] v;
    v = sink_level[6:0];
    while (sink_level[6:0] === v) @(negedge clock);
    c = 0;
    v = sink_level[6:0];
    while (sink_level[6:0] === v) begin
      @(negedge clock);
      c++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      test_done;
    end
  end
  initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    rdchk(8'h13, 8'h00);
    i_host.wr(8'h13, 8'hB1);
    rdchk(8'h13, 8'hB1);
    rdchk(8'h14, 8'h00);
    i_host.wr(8'h10, 8'h03);
    chk({1'b0, sink_enable_bits}, 8'h03);
    gap(n);
    chk(8'(n), 8'(3 * T));
    repeat (30) @(negedge clock);
    chk({1'b0, sink_level[6:0]}, 8'h03);
    chk({1'b0, sink_level[13:7]}, 8'h03);
    i_host.wr(8'h10, 8'h00);
    gap(n);
    chk(8'(n), 8'(35 * T));
    repeat (160) @(negedge clock);
    chk({1'b0, sink_level[6:0]}, 8'h00);
    i_host.wr(8'h13, 8'h00);
    i_host.wr(8'h10, 8'hFF);
    repeat (2) @(negedge clock);
    chk({1'b0, sink_level[48:42]}, 8'h03);
    rdchk(8'h10, 8'h7F);
    i_host.wr(8'h10, 8'h00);
    repeat (2) @(negedge clock);
    chk({1'b0, sink_level[48:42]}, 8'h00);
    test_done;
  end
endmodule // tb_top
bind sink_current_fade fade_props i_props (.clock, .rst, .reg_write, .reg_read, .reg_addr, .reg_wdata,
  .reg_rdata, .sink_target, .sink_level, .sink_enable_bits);
